// *** logic/i2c_master_receive_sequencer.sv ***
// I2C master receive sequencer with AXI4-Lite register slave
`timescale 1ns/100ps
`include "i2c_rx_regs.svh"
module i2c_master_receive_sequencer #(
    parameter int unsigned ADDR_W  = 8,
    parameter int unsigned QUARTER = `QUARTER_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   irq,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe
);
    i2c_rx_pkg::seq_state_t state_q;
    logic [1:0]        phase_q;
    logic [3:0]        bit_q;
    logic [7:0]        shift_q;
    logic [7:0]        chan_transmit_byte_reg;
    logic [7:0]        chan_receive_byte_reg;
    logic [2:0]        chan_control_reg;
    logic [4:0]        mask_q;
    logic              ack_q;
    logic              nack_sent_q;
    logic              tx_full_q;
    logic              start_seen_q;
    logic              stop_seen_q;
    logic              rx_full_q;
    logic              nack_seen_q;
    logic              ev_start_q;
    logic              ev_stop_q;
    logic              ev_rx_q;
    logic              ev_nack_q;
    logic              clr_start_q;
    logic              clr_stop_q;
    logic              clr_nack_q;
    logic              load_tx_q;
    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic              wlane_q;
    logic              tick;
    logic [1:0]        pins_s;

    function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
        if (a == ADDR_W'(`CTL_OFS)) reg_sel = 5'h01;
        else if (a == ADDR_W'(`FLAG_OFS)) reg_sel = 5'h02;
        else if (a == ADDR_W'(`MASK_OFS)) reg_sel = 5'h04;
        else if (a == ADDR_W'(`TXB_OFS)) reg_sel = 5'h08;
        else if (a == ADDR_W'(`RXB_OFS)) reg_sel = 5'h10;
        else reg_sel = 5'h00;
    endfunction

    tick_div #(.DIV(QUARTER)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    pin_sync #(.W(2)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     ({scl_i, sda_i}),
        .level   (pins_s)
    );

    wire scl_s = pins_s[1];
    wire sda_s = pins_s[0];

    // Register bus decode
    wire [4:0] wsel    = reg_sel(awaddr_q);
    wire [4:0] rsel    = reg_sel(araddr);
    wire       wr_fire = aw_held_q & w_held_q & ~bvalid;
    wire       wr_lane = wr_fire & wlane_q;
    wire       wr_ctl  = wr_lane & wsel[0];
    wire       wr_flag = wr_lane & wsel[1];
    wire       wr_mask = wr_lane & wsel[2];
    wire       wr_txb  = wr_lane & wsel[3];
    wire       rd_fire = arvalid & arready;
    wire       rd_rxb  = rd_fire & rsel[4];
    wire       busy    = (state_q != i2c_rx_pkg::ST_IDLE);

    wire [5:0] flags = {busy, nack_seen_q, rx_full_q, stop_seen_q, start_seen_q, ~tx_full_q};
    wire [31:0] rd_word = rsel[0] ? {29'h0, chan_control_reg} :
                          rsel[1] ? {26'h0, flags} :
                          rsel[2] ? {27'h0, mask_q} :
                          rsel[3] ? {24'h0, chan_transmit_byte_reg} :
                          rsel[4] ? {24'h0, chan_receive_byte_reg} : 32'h0;

    // Sticky flags: a hardware set in the clearing cycle wins
    wire w1c_start = wr_flag & wdata_q[`FLG_START_BIT];
    wire w1c_stop  = wr_flag & wdata_q[`FLG_STOP_BIT];
    wire w1c_rx    = (wr_flag & wdata_q[`FLG_RXF_BIT]) | rd_rxb;
    wire w1c_nack  = wr_flag & wdata_q[`FLG_NACK_BIT];
    wire start_seen_d = ev_start_q | (start_seen_q & ~w1c_start);
    wire stop_seen_d  = ev_stop_q | (stop_seen_q & ~w1c_stop);
    wire rx_full_d    = ev_rx_q | (rx_full_q & ~w1c_rx);
    wire nack_seen_d  = ev_nack_q | (nack_seen_q & ~w1c_nack);
    wire tx_full_d    = wr_txb | (tx_full_q & ~load_tx_q);

    // Software write beats the hardware clear of a request bit
    wire start_req_d = wr_ctl ? wdata_q[`CTL_START_BIT] :
                       (chan_control_reg[`CTL_START_BIT] & ~clr_start_q);
    wire stop_req_d  = wr_ctl ? wdata_q[`CTL_STOP_BIT] :
                       (chan_control_reg[`CTL_STOP_BIT] & ~clr_stop_q);
    wire nack_req_d  = wr_ctl ? wdata_q[`CTL_NACK_BIT] :
                       (chan_control_reg[`CTL_NACK_BIT] & ~clr_nack_q);
    wire irq_d = |(flags[4:0] & mask_q);

    wire start_req = chan_control_reg[`CTL_START_BIT];
    wire stop_req  = chan_control_reg[`CTL_STOP_BIT];
    wire nack_req  = chan_control_reg[`CTL_NACK_BIT];
    wire last_slot = (bit_q == 4'h8);
    // Address bits drive low for zeros; receive slot drives low to acknowledge
    wire addr_drv  = last_slot ? 1'b0 : ~shift_q[7];
    wire recv_drv  = last_slot ? ~nack_req : 1'b0;
    wire bit_drv   = (state_q == i2c_rx_pkg::ST_ADDR) ? addr_drv : recv_drv;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_control_reg <= `CTL_RESET;
            mask_q           <= `MASK_RESET;
            start_seen_q     <= 1'b0;
            stop_seen_q      <= 1'b0;
            rx_full_q        <= 1'b0;
            nack_seen_q      <= 1'b0;
            tx_full_q        <= 1'b0;
            irq              <= 1'b0;
        end else begin
            chan_control_reg <= {nack_req_d, stop_req_d, start_req_d};
            mask_q           <= wr_mask ? wdata_q[4:0] : mask_q;
            start_seen_q     <= start_seen_d;
            stop_seen_q      <= stop_seen_d;
            rx_full_q        <= rx_full_d;
            nack_seen_q      <= nack_seen_d;
            tx_full_q        <= tx_full_d;
            irq              <= irq_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_transmit_byte_reg <= 8'h00;
        end else if (wr_txb) begin
            chan_transmit_byte_reg <= wdata_q[7:0];
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wlane_q   <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awaddr_q  <= awaddr;
                aw_held_q <= 1'b1;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                wdata_q  <= wdata;
                wlane_q  <= wstrb[0];
                w_held_q <= 1'b1;
                wready   <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (|wsel) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read channel: one outstanding read, answered the cycle after it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `RESP_OKAY;
        end else if (rd_fire) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= (|rsel) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // Bus sequencer; each quarter bit is one tick, phase 2 waits out stretching
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= i2c_rx_pkg::ST_IDLE;
            phase_q     <= 2'h0;
            bit_q       <= 4'h0;
            shift_q     <= 8'h00;
            ack_q       <= 1'b1;
            nack_sent_q <= 1'b0;
            scl_oe      <= 1'b0;
            sda_oe      <= 1'b0;
            chan_receive_byte_reg <= 8'h00;
            ev_start_q  <= 1'b0;
            ev_stop_q   <= 1'b0;
            ev_rx_q     <= 1'b0;
            ev_nack_q   <= 1'b0;
            clr_start_q <= 1'b0;
            clr_stop_q  <= 1'b0;
            clr_nack_q  <= 1'b0;
            load_tx_q   <= 1'b0;
        end else begin
            ev_start_q  <= 1'b0;
            ev_stop_q   <= 1'b0;
            ev_rx_q     <= 1'b0;
            ev_nack_q   <= 1'b0;
            clr_start_q <= 1'b0;
            clr_stop_q  <= 1'b0;
            clr_nack_q  <= 1'b0;
            load_tx_q   <= 1'b0;
            if (tick) begin
                case (state_q)
                    i2c_rx_pkg::ST_IDLE: begin
                        phase_q <= 2'h0;
                        if (start_req) begin
                            state_q <= i2c_rx_pkg::ST_START;
                        end
                    end
                    i2c_rx_pkg::ST_START: begin
                        case (phase_q)
                            2'h0: begin
                                sda_oe  <= 1'b0;
                                phase_q <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe  <= 1'b0;
                                phase_q <= 2'h2;
                            end
                            2'h2: begin
                                if (scl_s) begin
                                    sda_oe  <= 1'b1;
                                    phase_q <= 2'h3;
                                end
                            end
                            default: begin
                                scl_oe      <= 1'b1;
                                ev_start_q  <= 1'b1;
                                clr_start_q <= 1'b1;
                                phase_q     <= 2'h0;
                                state_q     <= i2c_rx_pkg::ST_TXWAIT;
                            end
                        endcase
                    end
                    i2c_rx_pkg::ST_TXWAIT: begin
                        if (tx_full_q) begin
                            shift_q   <= chan_transmit_byte_reg;
                            load_tx_q <= 1'b1;
                            bit_q     <= 4'h0;
                            state_q   <= i2c_rx_pkg::ST_ADDR;
                        end
                    end
                    i2c_rx_pkg::ST_ADDR, i2c_rx_pkg::ST_RECV: begin
                        case (phase_q)
                            2'h0: begin
                                sda_oe  <= bit_drv;
                                phase_q <= 2'h1;
                                if (last_slot) begin
                                    nack_sent_q <= nack_req;
                                end
                            end
                            2'h1: begin
                                scl_oe  <= 1'b0;
                                phase_q <= 2'h2;
                            end
                            2'h2: begin
                                if (scl_s) begin
                                    phase_q <= 2'h3;
                                    if (last_slot) begin
                                        ack_q <= sda_s;
                                    end else begin
                                        shift_q <= {shift_q[6:0], sda_s};
                                    end
                                end
                            end
                            default: begin
                                scl_oe  <= 1'b1;
                                phase_q <= 2'h0;
                                if (!last_slot) begin
                                    bit_q <= bit_q + 4'h1;
                                end else if (state_q == i2c_rx_pkg::ST_ADDR) begin
                                    bit_q <= 4'h0;
                                    if (ack_q) begin
                                        ev_nack_q <= 1'b1;
                                        state_q   <= i2c_rx_pkg::ST_HOLD;
                                    end else begin
                                        state_q <= i2c_rx_pkg::ST_RECV;
                                    end
                                end else begin
                                    bit_q   <= 4'h0;
                                    ev_rx_q <= 1'b1;
                                    chan_receive_byte_reg <= shift_q;
                                    if (nack_sent_q) begin
                                        clr_nack_q <= 1'b1;
                                        state_q    <= i2c_rx_pkg::ST_HOLD;
                                    end else begin
                                        state_q <= i2c_rx_pkg::ST_WAIT_RD;
                                    end
                                end
                            end
                        endcase
                    end
                    // SCL held low until software has read the byte, giving time to request NACK
                    i2c_rx_pkg::ST_WAIT_RD: begin
                        if (stop_req) begin
                            state_q <= i2c_rx_pkg::ST_STOP;
                        end else if (!rx_full_q && !ev_rx_q) begin
                            state_q <= i2c_rx_pkg::ST_RECV;
                        end
                    end
                    i2c_rx_pkg::ST_HOLD: begin
                        if (stop_req) begin
                            state_q <= i2c_rx_pkg::ST_STOP;
                        end else if (start_req) begin
                            state_q <= i2c_rx_pkg::ST_START;
                        end
                    end
                    i2c_rx_pkg::ST_STOP: begin
                        case (phase_q)
                            2'h0: begin
                                sda_oe  <= 1'b1;
                                phase_q <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe  <= 1'b0;
                                phase_q <= 2'h2;
                            end
                            2'h2: begin
                                if (scl_s) begin
                                    sda_oe  <= 1'b0;
                                    phase_q <= 2'h3;
                                end
                            end
                            default: begin
                                ev_stop_q  <= 1'b1;
                                clr_stop_q <= 1'b1;
                                phase_q    <= 2'h0;
                                state_q    <= i2c_rx_pkg::ST_IDLE;
                            end
                        endcase
                    end
                    default: begin
                        state_q <= i2c_rx_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// *** pkg/i2c_rx_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef I2C_RX_REGS_SVH
`define I2C_RX_REGS_SVH

`define CTL_OFS        8'h00
`define FLAG_OFS       8'h04
`define MASK_OFS       8'h08
`define TXB_OFS        8'h0C
`define RXB_OFS        8'h10

`define CTL_START_BIT  0
`define CTL_STOP_BIT   1
`define CTL_NACK_BIT   2
`define CTL_RESET      3'h0

`define FLG_TXE_BIT    0
`define FLG_START_BIT  1
`define FLG_STOP_BIT   2
`define FLG_RXF_BIT    3
`define FLG_NACK_BIT   4
`define FLG_BUSY_BIT   5
`define MASK_RESET     5'h00

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`define CLK_HZ         20000000
`define SCL_HZ         100000
`define QUARTER_CYC    (`CLK_HZ / (4 * `SCL_HZ))

`endif

// *** pkg/i2c_rx_pkg.sv ***
// Types shared by the receive sequencer
package i2c_rx_pkg;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_START   = 8'h02,
        ST_TXWAIT  = 8'h04,
        ST_ADDR    = 8'h08,
        ST_RECV    = 8'h10,
        ST_WAIT_RD = 8'h20,
        ST_HOLD    = 8'h40,
        ST_STOP    = 8'h80
    } seq_state_t;

endpackage

// *** logic/pin_sync.sv ***
// Three-stage synchroniser with agreement filter for bus pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned W = 2
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    wire  [W-1:0] agree = ~(s2_q ^ s3_q);

    // Idle bus level is high, so reset to ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            level <= '1;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= (s2_q & agree) | (level & ~agree);
        end
    end
endmodule

// *** logic/tick_div.sv ***
// Divider giving a one-cycle enable every DIV clocks
`timescale 1ns/100ps
module tick_div #(
    parameter int unsigned DIV = 50
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      tick
);
    localparam int unsigned CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + CW'(1);
            tick  <= 1'b0;
        end
    end
endmodule

// *** sim/i2c_slave_model.sv ***
// Addressed slave answering reads with a counting byte pattern
`timescale 1ns/100ps
module i2c_slave_model #(
    parameter logic [6:0] ADR = 7'h2A
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      pull
);
    logic [7:0] sh;
    logic [7:0] dat;
    logic       nak;
    initial pull = 1'b0;
    // Released data goes to the pull-up level, never the last value
    always begin
        @(negedge sda iff scl === 1'b1);
        pull = 1'b0;
        repeat (8) @(posedge scl) sh = {sh[6:0], sda};
        @(negedge scl);
        if (sh === {ADR, 1'b1}) begin
            pull = 1'b1;
            dat = 8'hA5;
            @(negedge scl);
            do begin
                for (int i = 7; i >= 0; i--) begin
                    pull = ~dat[i];
                    @(negedge scl);
                end
                pull = 1'b0;
                @(posedge scl) nak = sda;
                @(negedge scl);
                dat = dat + 8'h11;
            end while (nak !== 1'b1);
        end
    end
endmodule

// *** sim/i2c_rx_chk.sv ***
// Bus handshake and pin timing assertions for the sequencer
`timescale 1ns/100ps
module i2c_rx_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    input wire logic        scl_oe,
    input wire logic        sda_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_aw_refused: assert property (awvalid && awready |=> !awready)
        else $error("awready high after its handshake");
    a_ar_refused: assert property (arvalid && arready |=> !arready)
        else $error("arready high after its handshake");
    a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write response not released");
    a_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_reset_idle: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !scl_oe && !irq)
        else $error("outputs not idle after reset");
    // A start pulls data with clock released, then the clock must follow
    a_start_shape: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:300] scl_oe)
        else $error("clock not pulled after start");
    a_stop_idle: assert property ($fell(sda_oe) && !scl_oe |=> !scl_oe [*4])
        else $error("clock pulled after stop");
endmodule
bind i2c_master_receive_sequencer i2c_rx_chk i_chk (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .irq,
    .scl_oe, .sda_oe);

// *** sim/tb_top.sv ***
// Self-checking bench for the I2C master receive sequencer
`timescale 1ns/100ps
`include "i2c_rx_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    localparam logic [6:0] ADR = 7'h2A;
    logic        aclk = 1'b0, aresetn = 1'b0, pull, scl, sda;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdv;
    logic [1:0]  bresp, rresp, rrv;
    logic        awready, wready, bvalid, arready, rvalid, irq, scl_oe, sda_oe, scl_o, sda_o;
    int          err_total = 0, compares = 0;
    always #25 aclk = ~aclk;
    // Pull-ups hold both lines high unless a side pulls them low
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;
    // Short quarter bit keeps each byte near 180 clocks
    i2c_master_receive_sequencer #(.QUARTER(4)) i_i2c_master_receive_sequencer (.aclk,
        .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
        .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
    i2c_slave_model #(.ADR(ADR)) i_i2c_slave_model (.scl, .sda, .pull);
    task automatic stop_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ready and valid are read at the falling edge so no edge race arises
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic ta, tw, v;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            v = bvalid;
            rrv = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (v) begin
                bready <= 1'b0;
                `CHK(rrv, er)
                return;
            end
        end
        err_total++;
        stop_test();
    endtask
    // A late rready lets the read data be seen standing
    task automatic rd(input logic [7:0] a, input int lag = 0);
        logic t, v;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            t = arvalid && arready;
            v = rvalid && rready;
            rdv = rdata;
            rrv = rresp;
            @(posedge aclk);
            if (t) arvalid <= 1'b0;
            if (v) begin
                rready <= 1'b0;
                return;
            end
            if (n >= lag) rready <= 1'b1;
        end
        err_total++;
        stop_test();
    endtask
    task automatic wait_flag(input int b);
        for (int n = 0; n < 400; n++) begin
            rd(`FLAG_OFS);
            if (rdv[b] === 1'b1) return;
        end
        err_total++;
        stop_test();
    endtask
    task automatic begin_rd(input logic [6:0] a, input logic nk);
        wr(`CTL_OFS, {29'h0, nk, 2'h1});
        wait_flag(`FLG_START_BIT);
        `CHK(rdv[`FLG_TXE_BIT], 1'b1)
        `CHK(irq, 1'b1)
        wr(`FLAG_OFS, 32'h2);
        rd(`FLAG_OFS);
        `CHK(rdv[`FLG_START_BIT], 1'b0)
        wr(`TXB_OFS, {24'h0, a, 1'b1});
    endtask
    task automatic rx_byte(input logic [7:0] e, input logic nk, input logic last);
        wait_flag(`FLG_RXF_BIT);
        `CHK(i_i2c_slave_model.nak, last)
        if (nk) wr(`CTL_OFS, 32'h4);
        rd(`RXB_OFS);
        `CHK(rdv, {24'h0, e})
    endtask
    task automatic end_rd();
        wr(`CTL_OFS, 32'h2);
        wait_flag(`FLG_STOP_BIT);
        wr(`FLAG_OFS, 32'h4);
        rd(`CTL_OFS);
        `CHK(rdv, 32'h0)
        `CHK(irq, 1'b0)
    endtask
    task automatic t_regs();
        rd(`CTL_OFS);
        `CHK(rdv, 32'h0)
        rd(`MASK_OFS, 3);
        `CHK(rdv, 32'h0)
        rd(8'h14);
        `CHK(rrv, `RESP_SLVERR)
        wr(8'h18, 32'h1, `RESP_SLVERR);
        wr(`MASK_OFS, 32'h1E);
    endtask
    task automatic t_multi();
        begin_rd(ADR, 1'b0);
        rx_byte(8'hA5, 1'b0, 1'b0);
        rx_byte(8'hB6, 1'b1, 1'b0);
        rx_byte(8'hC7, 1'b0, 1'b1);
        end_rd();
    endtask
    task automatic t_addr_nack();
        begin_rd(ADR ^ 7'h01, 1'b0);
        wait_flag(`FLG_NACK_BIT);
        wr(`MASK_OFS, 32'h0);
        rd(`FLAG_OFS);
        `CHK(irq, 1'b0)
        wr(`MASK_OFS, 32'h1E);
        rd(`FLAG_OFS);
        `CHK(irq, 1'b1)
        wr(`FLAG_OFS, 32'h10);
        rd(`FLAG_OFS);
        `CHK(rdv[`FLG_NACK_BIT], 1'b0)
        // Retry with a repeated START straight from the hold
        begin_rd(ADR, 1'b1);
        rx_byte(8'hA5, 1'b0, 1'b1);
        end_rd();
    endtask
    task automatic t_single();
        begin_rd(ADR, 1'b1);
        rx_byte(8'hA5, 1'b0, 1'b1);
        end_rd();
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_multi();
        t_single();
        t_addr_nack();
        stop_test();
    end
endmodule
